// [logic/fsv_pkg.sv]
`default_nettype none
package fsv_pkg;
  // =========================================================
  // clock and timing
  // =========================================================
  localparam int CLK_MHZ  = 100;
  localparam int TICK_US  = 1000;             // base tick, microseconds
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int COIN_MS  = 40;               // two-key coincidence window
  localparam int HOLD_MS  = 1000;             // press-and-hold time
  localparam int SHOW_MS  = 2000;             // announce gain display time
  localparam int FLASH_MS = 250;              // indicator half period
  localparam int MSW      = 11;               // width of the ms counters

  // =========================================================
  // enumerations
  // =========================================================
  typedef enum logic [1:0] {
    FSV_VIEW_MAIN = 2'b00,
    FSV_VIEW_AUX  = 2'b01,
    FSV_VIEW_SET  = 2'b10
  } fsv_view_e;

  typedef enum logic [1:0] {
    FSV_KEY_IDLE = 2'b00,
    FSV_KEY_WAIT = 2'b01,
    FSV_KEY_HELD = 2'b10,
    FSV_KEY_DONE = 2'b11
  } fsv_key_e;

  localparam logic [1:0] SPAN_WIDE   = 2'h0;
  localparam logic [1:0] SPAN_FADE   = 2'h1;
  localparam logic [1:0] SPAN_NARROW = 2'h2;
  localparam logic [1:0] TB_OFF      = 2'h0;
  localparam logic [1:0] TB_BUILTIN  = 2'h1;
  localparam logic [1:0] TB_EXT      = 2'h2;

  // =========================================================
  // gains, in dB
  // =========================================================
  localparam logic signed [7:0] ANN_MIN      = -8'sd46;
  localparam logic signed [7:0] ANN_MAX      = 8'sd6;
  localparam logic signed [7:0] ANN_RST      = 8'sd0;
  localparam logic signed [9:0] FDR_TOP_DB   = 10'sd15;
  localparam logic signed [9:0] FDR_FADE_DB  = 10'sd0;
  localparam logic signed [9:0] FDR_LOW_DB   = -10'sd15;
  localparam logic signed [9:0] FDR_OFF_DB   = -10'sd60;
  localparam logic [7:0]        FDR_OFF_CODE = 8'h80;
  localparam logic [7:0]        UNITY_RST    = 8'h80;

  // =========================================================
  // register map, byte addresses
  // =========================================================
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_DEST    = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_ROUTE   = 8'h0C;
  localparam logic [7:0] REG_AUX     = 8'h10;
  localparam logic [7:0] REG_AUXPOST = 8'h14;
  localparam logic [7:0] REG_INSET   = 8'h18;
  localparam logic [7:0] REG_POLSOLO = 8'h1C;
  localparam logic [7:0] REG_UNITY0  = 8'h20;  // 8 words, one per fader
  localparam logic [7:0] REG_UNITY7  = 8'h3C;
  localparam int CTRL_SPAN_LSB = 0;
  localparam int CTRL_TB_LSB   = 2;
  localparam int CTRL_CAL_BIT  = 4;
  localparam logic [15:0] DEST_RST = 16'hFFFF;
endpackage : fsv_pkg
`default_nettype wire

// [logic/fsv_fader_surface.sv]
// Operation
// RULE1: view button steps main, aux, settings
// RULE2: settings view returns to main view
// RULE3: start and reconnect enter main view
// RULE4: main view keys toggle left, right routing
// RULE5: main view both keys toggle solo
// RULE6: aux view keys toggle aux one, two
// RULE7: aux view darkens other indicators; the solo indicator stays lit in every view
// RULE8: aux indicator green prefade, red postfade
// RULE9: aux view key hold swaps pre/post
// RULE10: unassigned aux indicator flashes
// RULE11: settings keys: limiter, highpass, both polarity
// RULE12: settings: routing dark, yellow/blue status
// RULE13: all-off settings indicators flash
// RULE14: fader span wide, fade-only or narrow
// RULE15: fader gain relative, post-fade paths only
// RULE16: calibration stores fader positions as unity
// RULE17: announce gain 1 dB steps, -46..6
// RULE18: gain adjusts on main screen, shown briefly
// RULE19: announce active only while button held
// RULE20: talkback source; disabled ignores announce
// RULE21: input 8 silenced while announce active
// RULE22: external talkback blocks input 8 routing
// RULE23: talkback replaces feed at mapped destinations
// RULE24: coincident keys win over single actions
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fsv_fader_surface #(
  parameter int TICK_CYCLES = fsv_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // register port
  input  wire logic [7:0]       i_addr,
  input  wire logic [15:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [15:0]      o_rdata,
  // surface controls
  input  wire logic             i_present,
  input  wire logic             i_view_btn,
  input  wire logic [7:0]       i_key_a,
  input  wire logic [7:0]       i_key_b,
  input  wire logic [7:0][7:0]  i_fader_pos,
  input  wire logic             i_ann_btn,
  input  wire logic             i_rot_up,
  input  wire logic             i_rot_dn,
  input  wire logic             i_main_screen,
  // indicators
  output logic [7:0]            o_led_l_blu,
  output logic [7:0]            o_led_r_blu,
  output logic [7:0]            o_led_x1_grn,
  output logic [7:0]            o_led_x1_red,
  output logic [7:0]            o_led_x2_grn,
  output logic [7:0]            o_led_x2_red,
  output logic [7:0]            o_led_lim_yel,
  output logic [7:0]            o_led_hpf_yel,
  output logic [7:0]            o_led_pol_blu,
  output logic [7:0]            o_led_solo_yel,
  output fsv_pkg::fsv_view_e    o_view,
  // mixer controls
  output logic [7:0][7:0]       o_fader_gain,
  output logic [7:0]            o_aux1_post,
  output logic [7:0]            o_aux2_post,
  output logic                  o_ann_active,
  output logic [7:0]            o_ann_gain,
  output logic                  o_gain_show,
  output logic                  o_in8_silence,
  output logic [15:0]           o_talk_dest
);
  import fsv_pkg::*;

  // =========================================================
  // millisecond tick and flash phase
  // =========================================================
  logic [16:0]    tick_cnt_q;
  logic           tick_q;
  logic [MSW-1:0] flash_cnt_q;
  logic           flash_q;

  // one tick per ms drives every slow counter
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_q <= 17'h0_0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == 17'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 17'(TICK_CYCLES - 1)) ? 17'h0_0000 : tick_cnt_q + 17'h0_0001;
    end
  end

  // common flash phase keeps all indicators blinking in step
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else if (tick_q) begin
      flash_cnt_q <= (flash_cnt_q == MSW'(FLASH_MS - 1)) ? '0 : flash_cnt_q + 1'b1;
      if (flash_cnt_q == MSW'(FLASH_MS - 1)) begin
        flash_q <= ~flash_q;
      end
    end
  end

  // =========================================================
  // register port decode
  // =========================================================
  logic [1:0]  span_q;
  logic [1:0]  tb_q;
  logic [15:0] dest_q;
  logic [7:0]  unity_q [8];
  wire         wr_ctrl = i_wr && (i_addr == REG_CTRL);
  wire         wr_dest = i_wr && (i_addr == REG_DEST);
  wire         cal_go  = wr_ctrl && i_wdata[CTRL_CAL_BIT];

  // software setup; calibration bit is a pulse, never stored
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      span_q <= SPAN_WIDE;
      tb_q   <= TB_OFF;
      dest_q <= DEST_RST;
    end else begin
      if (wr_ctrl) begin
        span_q <= i_wdata[CTRL_SPAN_LSB +: 2];
        tb_q   <= i_wdata[CTRL_TB_LSB +: 2];
      end
      if (wr_dest) begin
        dest_q <= i_wdata;
      end
    end
  end

  // RULE16: capture unity points
  // operator parks every fader at 0 dB before confirming
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 8; i++) begin
        unity_q[i] <= UNITY_RST;
      end
    end else if (cal_go) begin
      for (int i = 0; i < 8; i++) begin
        unity_q[i] <= i_fader_pos[i];
      end
    end
  end

  // =========================================================
  // view cycling
  // =========================================================
  fsv_view_e view_q;
  logic      view_btn_q;
  wire       view_press = i_view_btn && !view_btn_q;
  wire       is_main    = (view_q == FSV_VIEW_MAIN);
  wire       is_aux     = (view_q == FSV_VIEW_AUX);
  wire       is_set     = (view_q == FSV_VIEW_SET);

  // RULE3: main after connect
  // while the surface is absent the view is held at main
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      view_q     <= FSV_VIEW_MAIN;
      view_btn_q <= 1'b0;
    end else begin
      view_btn_q <= i_view_btn;
      if (!i_present) begin
        view_q <= FSV_VIEW_MAIN;
      end else if (view_press) begin
        // RULE1: step view loop
        case (view_q)
          FSV_VIEW_MAIN: view_q <= FSV_VIEW_AUX;
          FSV_VIEW_AUX:  view_q <= FSV_VIEW_SET;
          // RULE2: settings to main
          FSV_VIEW_SET:  view_q <= FSV_VIEW_MAIN;
          default:       view_q <= FSV_VIEW_MAIN;
        endcase
      end
    end
  end

  // =========================================================
  // select key decoding, one machine per input
  // =========================================================
  fsv_key_e       key_st_q  [8];
  logic [MSW-1:0] key_cnt_q [8];
  logic [7:0]     ev_a_q;
  logic [7:0]     ev_b_q;
  logic [7:0]     ev_la_q;
  logic [7:0]     ev_lb_q;
  logic [7:0]     ev_ab_q;

  // RULE24: coincidence window first
  // a single action fires only once the window closed without the
  // other key; the cost is a short delay on every single press
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 8; i++) begin
        key_st_q[i]  <= FSV_KEY_IDLE;
        key_cnt_q[i] <= '0;
      end
      ev_a_q  <= 8'h00;
      ev_b_q  <= 8'h00;
      ev_la_q <= 8'h00;
      ev_lb_q <= 8'h00;
      ev_ab_q <= 8'h00;
    end else begin
      ev_a_q  <= 8'h00;
      ev_b_q  <= 8'h00;
      ev_la_q <= 8'h00;
      ev_lb_q <= 8'h00;
      ev_ab_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        case (key_st_q[i])
          FSV_KEY_IDLE: begin
            key_cnt_q[i] <= '0;
            if (i_key_a[i] && i_key_b[i]) begin
              ev_ab_q[i]  <= 1'b1;
              key_st_q[i] <= FSV_KEY_DONE;
            end else if (i_key_a[i] || i_key_b[i]) begin
              key_st_q[i] <= FSV_KEY_WAIT;
            end
          end
          FSV_KEY_WAIT: begin
            if (i_key_a[i] && i_key_b[i]) begin
              ev_ab_q[i]  <= 1'b1;
              key_st_q[i] <= FSV_KEY_DONE;
            end else if (!i_key_a[i] && !i_key_b[i]) begin
              key_st_q[i] <= FSV_KEY_IDLE;
            end else if (tick_q) begin
              key_cnt_q[i] <= key_cnt_q[i] + 1'b1;
              if (key_cnt_q[i] == MSW'(COIN_MS - 1)) begin
                key_cnt_q[i] <= '0;
                key_st_q[i]  <= FSV_KEY_HELD;
              end
            end
          end
          FSV_KEY_HELD: begin
            // short press fires on release, long press at hold time
            if (!i_key_a[i] && !i_key_b[i]) begin
              ev_a_q[i]   <= ev_key_a(i);
              ev_b_q[i]   <= !ev_key_a(i);
              key_st_q[i] <= FSV_KEY_IDLE;
            end else if (tick_q) begin
              key_cnt_q[i] <= key_cnt_q[i] + 1'b1;
              if (key_cnt_q[i] == MSW'(HOLD_MS - 1)) begin
                ev_la_q[i]  <= i_key_a[i];
                ev_lb_q[i]  <= !i_key_a[i];
                key_st_q[i] <= FSV_KEY_DONE;
              end
            end
          end
          FSV_KEY_DONE: begin
            if (!i_key_a[i] && !i_key_b[i]) begin
              key_st_q[i] <= FSV_KEY_IDLE;
            end
          end
          default: key_st_q[i] <= FSV_KEY_IDLE;
        endcase
      end
    end
  end

  // key that opened a held press, tracked so release knows its owner
  logic [7:0] held_a_q;
  function automatic logic ev_key_a(input int idx);
    ev_key_a = held_a_q[idx];
  endfunction : ev_key_a

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      held_a_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (key_st_q[i] == FSV_KEY_WAIT) begin
          held_a_q[i] <= i_key_a[i];
        end
      end
    end
  end

  // =========================================================
  // per-input action decode
  // =========================================================
  logic [7:0] route_l_q, route_r_q, solo_q;
  logic [7:0] aux1_q, aux2_q, aux1_post_q, aux2_post_q;
  logic [7:0] lim_q, hpf_q, pol_q;
  wire  [7:0] press_a = ev_a_q | ev_la_q;
  wire  [7:0] press_b = ev_b_q | ev_lb_q;
  // RULE22: input 8 unroutable
  wire  [7:0] blk     = {tb_q == TB_EXT, 7'h00};
  // RULE4: main left/right toggles
  wire  [7:0] tog_l   = {8{is_main}} & press_a;
  wire  [7:0] tog_r   = {8{is_main}} & press_b;
  // RULE5: main solo toggle
  wire  [7:0] tog_so  = {8{is_main}} & ev_ab_q;
  // RULE6: aux assignment toggles
  wire  [7:0] tog_x1  = {8{is_aux}} & ev_a_q;
  wire  [7:0] tog_x2  = {8{is_aux}} & ev_b_q;
  // RULE9: hold swaps pre/post
  wire  [7:0] sw_x1   = {8{is_aux}} & ev_la_q;
  wire  [7:0] sw_x2   = {8{is_aux}} & ev_lb_q;
  // RULE11: settings key actions
  wire  [7:0] tog_lim = {8{is_set}} & press_a;
  wire  [7:0] tog_hpf = {8{is_set}} & press_b;
  wire  [7:0] tog_pol = {8{is_set}} & ev_ab_q;

  // input state; a blocked input 8 loses every track route
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      route_l_q   <= 8'h00;
      route_r_q   <= 8'h00;
      solo_q      <= 8'h00;
      aux1_q      <= 8'h00;
      aux2_q      <= 8'h00;
      aux1_post_q <= 8'h00;
      aux2_post_q <= 8'h00;
      lim_q       <= 8'h00;
      hpf_q       <= 8'h00;
      pol_q       <= 8'h00;
    end else begin
      route_l_q   <= (route_l_q ^ tog_l) & ~blk;
      route_r_q   <= (route_r_q ^ tog_r) & ~blk;
      solo_q      <= solo_q ^ tog_so;
      aux1_q      <= (aux1_q ^ tog_x1) & ~blk;
      aux2_q      <= (aux2_q ^ tog_x2) & ~blk;
      aux1_post_q <= aux1_post_q ^ sw_x1;
      aux2_post_q <= aux2_post_q ^ sw_x2;
      lim_q       <= lim_q ^ tog_lim;
      hpf_q       <= hpf_q ^ tog_hpf;
      pol_q       <= pol_q ^ tog_pol;
    end
  end

  // =========================================================
  // indicator colours
  // =========================================================
  wire [7:0] fl      = {8{flash_q}};
  // RULE10: unassigned aux flashes
  wire [7:0] x1_grn  = (aux1_q & ~aux1_post_q) | (~aux1_q & fl);
  wire [7:0] x2_grn  = (aux2_q & ~aux2_post_q) | (~aux2_q & fl);
  // RULE8: green pre, red post
  wire [7:0] x1_red  = aux1_q & aux1_post_q;
  wire [7:0] x2_red  = aux2_q & aux2_post_q;
  // RULE13: flash when all off
  wire [7:0] all_off = ~lim_q & ~hpf_q & ~pol_q;
  wire [7:0] set_fl  = all_off & fl;
  wire [7:0] mn      = {8{is_main}};
  wire [7:0] ax      = {8{is_aux}};
  wire [7:0] st      = {8{is_set}};

  // RULE7: aux view darkens others except solo, which follows solo_q in every view
  // RULE12: settings view colours
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_led_l_blu    <= 8'h00;
      o_led_r_blu    <= 8'h00;
      o_led_x1_grn   <= 8'h00;
      o_led_x1_red   <= 8'h00;
      o_led_x2_grn   <= 8'h00;
      o_led_x2_red   <= 8'h00;
      o_led_lim_yel  <= 8'h00;
      o_led_hpf_yel  <= 8'h00;
      o_led_pol_blu  <= 8'h00;
      o_led_solo_yel <= 8'h00;
    end else begin
      o_led_l_blu    <= mn & route_l_q;
      o_led_r_blu    <= mn & route_r_q;
      o_led_x1_grn   <= (mn & aux1_q & ~aux1_post_q) | (ax & x1_grn);
      o_led_x1_red   <= (mn | ax) & x1_red;
      o_led_x2_grn   <= (mn & aux2_q & ~aux2_post_q) | (ax & x2_grn);
      o_led_x2_red   <= (mn | ax) & x2_red;
      o_led_lim_yel  <= (mn & lim_q) | (st & (lim_q | set_fl));
      o_led_hpf_yel  <= (mn & hpf_q) | (st & (hpf_q | set_fl));
      o_led_pol_blu  <= (mn & pol_q) | (st & (pol_q | set_fl));
      o_led_solo_yel <= solo_q;
    end
  end

  // =========================================================
  // fader gain
  // =========================================================
  // RULE14: span mapping
  // one position step is one dB about the unity point
  function automatic logic [7:0] fader_map(input logic [7:0] pos,
                                           input logic [7:0] uni,
                                           input logic [1:0] span);
    logic signed [9:0] d;
    d = $signed({2'b00, pos}) - $signed({2'b00, uni});
    if (span == SPAN_FADE && d > FDR_FADE_DB) begin
      d = FDR_FADE_DB;
    end else if (d > FDR_TOP_DB) begin
      d = FDR_TOP_DB;
    end
    if (span == SPAN_NARROW && d < FDR_LOW_DB) begin
      fader_map = FDR_LOW_DB[7:0];
    end else if (span != SPAN_NARROW && d < FDR_OFF_DB) begin
      fader_map = FDR_OFF_CODE;
    end else begin
      fader_map = d[7:0];
    end
  endfunction : fader_map

  // RULE15: relative, post-fade only
  // gain is relative to the stored unity point; mixer applies it to post-fade sends
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fader_gain <= '0;
      o_aux1_post  <= 8'h00;
      o_aux2_post  <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        o_fader_gain[i] <= fader_map(i_fader_pos[i], unity_q[i], span_q);
      end
      o_aux1_post <= aux1_q & aux1_post_q;
      o_aux2_post <= aux2_q & aux2_post_q;
    end
  end

  // =========================================================
  // announce (talkback slate)
  // =========================================================
  logic signed [7:0] ann_gain_q;
  logic [MSW-1:0]    show_cnt_q;
  // RULE19: active while held
  // RULE20: disabled source ignores button
  wire               ann_on  = i_ann_btn && (tb_q != TB_OFF);
  // RULE18: main screen only
  wire               adj_ok  = ann_on && i_main_screen;
  wire               g_up    = adj_ok && i_rot_up && !i_rot_dn && (ann_gain_q < ANN_MAX);
  wire               g_dn    = adj_ok && i_rot_dn && !i_rot_up && (ann_gain_q > ANN_MIN);

  // RULE17: 1 dB clamped steps
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ann_gain_q <= ANN_RST;
      show_cnt_q <= '0;
    end else begin
      if (g_up) begin
        ann_gain_q <= ann_gain_q + 8'sd1;
      end else if (g_dn) begin
        ann_gain_q <= ann_gain_q - 8'sd1;
      end
      // display restarts on every step, then times out
      if (g_up || g_dn) begin
        show_cnt_q <= MSW'(SHOW_MS);
      end else if (tick_q && show_cnt_q != '0) begin
        show_cnt_q <= show_cnt_q - 1'b1;
      end
    end
  end

  // RULE21: silence input 8
  // RULE23: talkback at mapped destinations
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ann_active  <= 1'b0;
      o_in8_silence <= 1'b0;
      o_talk_dest   <= 16'h0000;
      o_ann_gain    <= 8'h00;
      o_gain_show   <= 1'b0;
      o_view        <= FSV_VIEW_MAIN;
    end else begin
      o_ann_active  <= ann_on;
      o_in8_silence <= ann_on;
      o_talk_dest   <= ann_on ? dest_q : 16'h0000;
      o_ann_gain    <= ann_gain_q;
      o_gain_show   <= (show_cnt_q != '0);
      o_view        <= view_q;
    end
  end

  // =========================================================
  // register read-back, data valid the cycle after the strobe
  // =========================================================
  wire        in_unity = (i_addr >= REG_UNITY0) && (i_addr <= REG_UNITY7) && (i_addr[1:0] == 2'b00);
  wire [2:0]  u_idx    = 3'(i_addr[7:2] - REG_UNITY0[7:2]);
  wire [15:0] rd_mux   =
      (i_addr == REG_CTRL)    ? {12'h000, tb_q, span_q} :
      (i_addr == REG_DEST)    ? dest_q :
      (i_addr == REG_STATUS)  ? {ann_gain_q, 5'h00, ann_on, view_q} :
      (i_addr == REG_ROUTE)   ? {route_r_q, route_l_q} :
      (i_addr == REG_AUX)     ? {aux2_q, aux1_q} :
      (i_addr == REG_AUXPOST) ? {aux2_post_q, aux1_post_q} :
      (i_addr == REG_INSET)   ? {hpf_q, lim_q} :
      (i_addr == REG_POLSOLO) ? {solo_q, pol_q} :
      in_unity                ? {8'h00, unity_q[u_idx]} :
                                16'h0000;

  // read data stands in each cycle after i_rd was high, zero otherwise
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

endmodule : fsv_fader_surface
`default_nettype wire

// [sim/fsv_fader_surface_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module fsv_fader_surface_asserts
  import fsv_pkg::*;
(
  input wire logic             i_clk, i_rst_b, i_present, i_ann_btn,
  input wire fsv_view_e        o_view,
  input wire logic             o_ann_active, o_in8_silence,
  input wire logic [7:0]       o_ann_gain, o_led_l_blu, o_led_r_blu, o_led_lim_yel,
  input wire logic [7:0]       o_led_hpf_yel, o_led_pol_blu, o_led_x1_grn, o_led_x1_red,
  input wire logic [7:0]       o_led_x2_grn, o_led_x2_red,
  input wire logic [15:0]      o_talk_dest
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // grouped indicator lines keep the dark checks short
  wire logic [7:0] lr = o_led_l_blu | o_led_r_blu;
  wire logic [7:0] xa = o_led_x1_grn | o_led_x1_red | o_led_x2_grn | o_led_x2_red;
  a_view_step: assert property ($changed(o_view) && i_present && $past(i_present) |->
    o_view == (($past(o_view) == FSV_VIEW_SET) ? FSV_VIEW_MAIN : fsv_view_e'($past(o_view) + 2'd1)))
    else $error("view stepped out of order");
  a_view_legal: assert property (o_view != 2'b11) else $error("illegal view code");
  a_present_main: assert property (!i_present [*3] |-> o_view == FSV_VIEW_MAIN)
    else $error("view not main while absent");
  a_aux_dark: assert property (o_view == FSV_VIEW_AUX && $past(o_view) == FSV_VIEW_AUX |->
    (lr | o_led_lim_yel | o_led_hpf_yel | o_led_pol_blu) == 8'h00) else $error("aux view lit");
  a_set_dark: assert property (o_view == FSV_VIEW_SET && $past(o_view) == FSV_VIEW_SET |->
    (lr | xa) == 8'h00) else $error("settings view lit routing");
  a_gain_clamp: assert property ($signed(o_ann_gain) >= -46 && $signed(o_ann_gain) <= 6)
    else $error("announce gain out of range");
  a_gain_step: assert property ($changed(o_ann_gain) |->
    (o_ann_gain - $past(o_ann_gain)) inside {8'h01, 8'hFF}) else $error("gain jump");
  a_ann_release: assert property (!i_ann_btn |=> !o_ann_active)
    else $error("announce outlived button");
  a_in8_silence: assert property (o_in8_silence == o_ann_active)
    else $error("input 8 silence mismatch");
  a_dest_idle: assert property (!o_ann_active |-> o_talk_dest == 16'h0000)
    else $error("destinations driven while idle");
endmodule : fsv_fader_surface_asserts
bind fsv_fader_surface fsv_fader_surface_asserts fsv_fader_surface_asserts_i (.i_clk, .i_rst_b,
  .i_present, .i_ann_btn, .o_view, .o_ann_active, .o_in8_silence, .o_ann_gain, .o_led_l_blu,
  .o_led_r_blu, .o_led_lim_yel, .o_led_hpf_yel, .o_led_pol_blu, .o_led_x1_grn, .o_led_x1_red,
  .o_led_x2_grn, .o_led_x2_red, .o_talk_dest);
`default_nettype wire

// [sim/fsv_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fsv_host_model (
  input  wire logic i_clk,
  output logic      o_rot_up,
  output logic      o_rot_dn,
  output logic      o_main_screen
);
  initial begin
    o_rot_up = 1'b0;
    o_rot_dn = 1'b0;
    o_main_screen = 1'b1;
  end
  task automatic screen(input logic on);
    @(posedge i_clk);
    o_main_screen <= on;
  endtask : screen
  task automatic turn(input int n, input logic up);
    repeat (n) begin
      @(posedge i_clk);
      o_rot_up <= up;
      o_rot_dn <= !up;
    end
    @(posedge i_clk);
    o_rot_up <= 1'b0;
    o_rot_dn <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : turn
endmodule : fsv_host_model
`default_nettype wire

// [sim/fsv_fader_surface_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module fsv_fader_surface_tb;
  import fsv_pkg::*;
  logic i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, i_present = 1, i_view_btn = 0, i_ann_btn = 0;
  logic [7:0] i_addr = 0, i_key_a = 0, i_key_b = 0;
  logic [15:0] i_wdata = 0, o_rdata, o_talk_dest, rd_v;
  logic [7:0][7:0] i_fader_pos = {8{8'h90}}, o_fader_gain;
  logic [7:0] o_led_l_blu, o_led_r_blu, o_led_x1_grn, o_led_x1_red, o_led_x2_grn, o_led_x2_red;
  logic [7:0] o_led_lim_yel, o_led_hpf_yel, o_led_pol_blu, o_led_solo_yel, o_aux1_post;
  logic [7:0] o_aux2_post, o_ann_gain;
  logic o_ann_active, o_gain_show, o_in8_silence, i_rot_up, i_rot_dn, i_main_screen;
  fsv_view_e o_view;
  int error_cnt = 0, compares = 0;
  always #5 i_clk = ~i_clk;
  // short tick: 40 ms window is 400 cycles
  fsv_fader_surface #(.TICK_CYCLES(10)) fsv_fader_surface_i (.i_clk, .i_rst_b, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_present, .i_view_btn, .i_key_a, .i_key_b, .i_fader_pos,
    .i_ann_btn, .i_rot_up, .i_rot_dn, .i_main_screen, .o_led_l_blu, .o_led_r_blu, .o_led_x1_grn,
    .o_led_x1_red, .o_led_x2_grn, .o_led_x2_red, .o_led_lim_yel, .o_led_hpf_yel, .o_led_pol_blu,
    .o_led_solo_yel, .o_view, .o_fader_gain, .o_aux1_post, .o_aux2_post, .o_ann_active,
    .o_ann_gain, .o_gain_show, .o_in8_silence, .o_talk_dest);
  fsv_host_model host_i (.i_clk, .o_rot_up(i_rot_up), .o_rot_dn(i_rot_dn),
    .o_main_screen(i_main_screen));
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1;
    @(posedge i_clk);
    i_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1;
    @(posedge i_clk);
    i_rd <= 0;
    #1 rd_v = o_rdata;
  endtask : rd
  task automatic view();
    @(posedge i_clk);
    i_view_btn <= 1;
    repeat (3) @(posedge i_clk);
    i_view_btn <= 0;
    repeat (3) @(posedge i_clk);
  endtask : view
  // presses outlast the window but stay short of a hold
  task automatic keys(input logic [7:0] a, input logic [7:0] b);
    @(posedge i_clk);
    i_key_a <= a;
    i_key_b <= b;
    repeat (600) @(posedge i_clk);
    i_key_a <= 0;
    i_key_b <= 0;
    repeat (20) @(posedge i_clk);
  endtask : keys
  task automatic summarize();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (30000) @(posedge i_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1;
    `CHK("view", FSV_VIEW_MAIN, o_view)
    rd(REG_DEST); `CHK("dest", DEST_RST, rd_v)
    `CHK("fdr", {8{8'h0F}}, o_fader_gain)
    rd(8'h40); `CHK("unmapped", 16'h0000, rd_v)
    keys(8'h85, 8'h06);
    rd(REG_ROUTE); `CHK("route", 16'h0281, rd_v)
    rd(REG_POLSOLO); `CHK("solo", 16'h0400, rd_v)
    view(); `CHK("view", FSV_VIEW_AUX, o_view)
    keys(8'h08, 8'h10);
    rd(REG_AUX); `CHK("aux", 16'h1008, rd_v)
    `CHK("x1 led", 8'h08, o_led_x1_grn & 8'h08)
    view(); `CHK("view", FSV_VIEW_SET, o_view)
    keys(8'h05, 8'h06);
    rd(REG_INSET); `CHK("inset", 16'h0201, rd_v)
    rd(REG_POLSOLO); `CHK("pol", 16'h0404, rd_v)
    `CHK("lim led", 8'h01, o_led_lim_yel)
    view(); `CHK("view", FSV_VIEW_MAIN, o_view)
    view();
    i_present <= 0;
    repeat (4) @(posedge i_clk);
    `CHK("absent", FSV_VIEW_MAIN, o_view)
    i_present <= 1;
    i_ann_btn <= 1;
    repeat (3) @(posedge i_clk);
    `CHK("ann off", 1'b0, o_ann_active)
    wr(REG_CTRL, 16'h0018);
    repeat (3) @(posedge i_clk);
    `CHK("ann", 1'b1, o_ann_active)
    `CHK("in8", 1'b1, o_in8_silence)
    `CHK("talk", DEST_RST, o_talk_dest)
    `CHK("cal", 64'h0, o_fader_gain)
    host_i.turn(8, 1'b1);
    `CHK("gain", 8'h06, o_ann_gain)
    host_i.screen(1'b0); host_i.turn(1, 1'b0);
    `CHK("gain", 8'h06, o_ann_gain)
    host_i.screen(1'b1); host_i.turn(60, 1'b0);
    `CHK("gain", 8'hD2, o_ann_gain)
    i_ann_btn <= 0;
    repeat (3) @(posedge i_clk);
    `CHK("ann", 1'b0, o_ann_active)
    rd(REG_ROUTE); `CHK("rt8", 16'h0201, rd_v)
    summarize();
  end
endmodule : fsv_fader_surface_tb
`default_nettype wire
